// [core/cpmd_decoder.sv]
/*
 * Control pin mode decoder: reads the four three-level control pins, picks
 * pin-strapped or extended serial control, and drives the resulting settings.
 * Assumes pad sensors give a level and a float bit per pin, synchronous
 * inputs in the core clock domain, and an APB master on the register port.
 */
`timescale 1ns/1ps

// ***********************************************
// Control pin mode decoder
// ***********************************************
module cpmd_decoder (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   // Three-level control pins, level and float from the pad sensors
   input wire logic mode_range_level_in,
   input wire logic mode_range_float_in,
   input wire logic output_swing_level_in,
   input wire logic output_swing_float_in,
   input wire logic output_edge_select_level_in,
   input wire logic output_edge_select_float_in,
   input wire logic calibration_delay_select_level_in,
   input wire logic calibration_delay_select_float_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic pready_out,
   output logic [31:0] prdata_out,
   output logic pslverr_out,
   // Decoded configuration to the datapath
   output logic ext_mode_out,
   output logic range_870_out,
   output logic swing_high_out,
   output logic data_edge_pos_out,
   output logic ddr_out,
   output logic cal_delay_long_out,
   output logic dual_edge_out,
   // Serial interface inputs routed from the shared pins
   output logic serial_enable_out,
   output logic serial_clock_out,
   output logic serial_data_input_out,
   output logic serial_select_input_out
);

   // ***********************************************
   // State and helpers
   // ***********************************************

   // All state of the decoder
   typedef struct packed {
      cpmd_pkg::cpmd_mode_t mode;
      logic range_870;
      logic swing_high;
      logic edge_pos;
      logic ddr;
      logic cal_long;
      logic des;
      logic serial_en;
      logic sclk;
      logic serial_data_input;
      logic ssel;
      logic [5:0] ext_cfg;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cpmd_state_t;

   cpmd_state_t st;
   cpmd_state_t next_st;

   // Synchronised pin codes {float, level}
   logic [1:0] code [cpmd_pkg::NUM_PINS];
   // Raw pad bits gathered for the generate loop
   logic [3:0] pin_level;
   logic [3:0] pin_float;
   // APB phase decode
   logic apb_setup;
   logic apb_access;

   // A pin reads high only when it is driven, never when floating
   function automatic logic pin_is_high(input logic [1:0] c);
      pin_is_high = !c[cpmd_pkg::PIN_FLOAT_BIT] && c[cpmd_pkg::PIN_LEVEL_BIT];
   endfunction : pin_is_high

   // Floating test, used by all four pins; the swing pin only for the status fault bit
   function automatic logic pin_is_float(input logic [1:0] c);
      pin_is_float = c[cpmd_pkg::PIN_FLOAT_BIT];
   endfunction : pin_is_float

   assign pin_level = {calibration_delay_select_level_in, output_edge_select_level_in,
                       output_swing_level_in, mode_range_level_in};
   assign pin_float = {calibration_delay_select_float_in, output_edge_select_float_in,
                       output_swing_float_in, mode_range_float_in};

   // ***********************************************
   // Pin synchronisers
   // ***********************************************

   // One synchroniser per pin; decode only sees the second stage
   generate
      for (genvar i = 0; i < cpmd_pkg::NUM_PINS; i++) begin : g_sync
         cpmd_pin_sync u_sync (
            .core_clk_in(core_clk_in),
            .arst_n_in(arst_n_in),
            .level_in(pin_level[i]),
            .float_in(pin_float[i]),
            .code_out(code[i])
         );
      end
   endgenerate

   // ***********************************************
   // Next-state logic
   // ***********************************************

   assign apb_setup = psel_in && !penable_in;
   assign apb_access = psel_in && penable_in && st.pready;

   // Decode of pins and register access
   always_comb begin
      next_st = st;
      if (pin_is_float(code[cpmd_pkg::PIN_MODE])) begin
         // Extended mode: settings come from the extended configuration
         next_st.mode = cpmd_pkg::CPMD_MODE_EXT;
         next_st.range_870 = st.ext_cfg[cpmd_pkg::CFG_RANGE_BIT];
         next_st.swing_high = st.ext_cfg[cpmd_pkg::CFG_SWING_BIT];
         next_st.edge_pos = st.ext_cfg[cpmd_pkg::CFG_EDGE_BIT];
         next_st.ddr = st.ext_cfg[cpmd_pkg::CFG_DDR_BIT];
         next_st.cal_long = st.ext_cfg[cpmd_pkg::CFG_CAL_BIT];
         next_st.des = st.ext_cfg[cpmd_pkg::CFG_DES_BIT];
         // Shared pins carry the host's serial signals
         next_st.serial_en = 1'b1;
         next_st.sclk = code[cpmd_pkg::PIN_SWING][cpmd_pkg::PIN_LEVEL_BIT];
         next_st.serial_data_input = code[cpmd_pkg::PIN_EDGE][cpmd_pkg::PIN_LEVEL_BIT];
         next_st.ssel = code[cpmd_pkg::PIN_CAL][cpmd_pkg::PIN_LEVEL_BIT];
      end else begin
         // Pin-strapped mode: every setting from the pin codes, ddr and des from the float bits
         next_st.mode = cpmd_pkg::CPMD_MODE_PIN;
         next_st.range_870 = pin_is_high(code[cpmd_pkg::PIN_MODE]);
         // A floating swing pin is not allowed here; it falls back to low
         next_st.swing_high = pin_is_high(code[cpmd_pkg::PIN_SWING]);
         next_st.edge_pos = pin_is_high(code[cpmd_pkg::PIN_EDGE]);
         next_st.ddr = pin_is_float(code[cpmd_pkg::PIN_EDGE]);
         next_st.cal_long = pin_is_high(code[cpmd_pkg::PIN_CAL]);
         next_st.des = pin_is_float(code[cpmd_pkg::PIN_CAL]);
         // Serial port held idle and deselected
         next_st.serial_en = 1'b0;
         next_st.sclk = 1'b0;
         next_st.serial_data_input = 1'b0;
         next_st.ssel = 1'b1;
      end

      // APB: answer one cycle after setup, zero wait in access
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      if (apb_setup) begin
         next_st.pready = 1'b1;
         if (paddr_in == cpmd_pkg::ADDR_EXT_CFG) begin
            next_st.prdata = {26'h00_0000, st.ext_cfg};
         end else if (paddr_in == cpmd_pkg::ADDR_STATUS) begin
            next_st.prdata = '0;
            for (int i = 0; i < cpmd_pkg::NUM_PINS; i++) begin
               next_st.prdata[cpmd_pkg::STAT_CODES_LSB + 2 * i +: 2] = code[i];
            end
            next_st.prdata[cpmd_pkg::STAT_EXT_BIT] = st.mode[1];
            next_st.prdata[cpmd_pkg::STAT_SWING_FAULT_BIT] =
               !st.mode[1] && pin_is_float(code[cpmd_pkg::PIN_SWING]);
         end else begin
            // Unmapped: read zero and flag an error
            next_st.prdata = '0;
            next_st.pslverr = 1'b1;
         end
      end else if (apb_access) begin
         // Write lands at the completing edge only
         if (pwrite_in && paddr_in == cpmd_pkg::ADDR_EXT_CFG) begin
            next_st.ext_cfg = pwdata_in[5:0];
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= '0;
         st.mode <= cpmd_pkg::CPMD_MODE_PIN;
         st.ssel <= 1'b1;
         st.ext_cfg <= cpmd_pkg::CFG_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************
   // Outputs, straight from the state register
   // ***********************************************
   assign pready_out = st.pready;
   assign prdata_out = st.prdata;
   assign pslverr_out = st.pslverr;
   assign ext_mode_out = st.mode[1];
   assign range_870_out = st.range_870;
   assign swing_high_out = st.swing_high;
   assign data_edge_pos_out = st.edge_pos;
   assign ddr_out = st.ddr;
   assign cal_delay_long_out = st.cal_long;
   assign dual_edge_out = st.des;
   assign serial_enable_out = st.serial_en;
   assign serial_clock_out = st.sclk;
   assign serial_data_input_out = st.serial_data_input;
   assign serial_select_input_out = st.ssel;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   a_mode_follows_pin: assert property (
      ##1 ext_mode_out == $past(code[0][1])) else $error("mode does not follow mode pin");
   a_serial_off_pin: assert property (
      !ext_mode_out |-> !serial_enable_out && !serial_clock_out && !serial_data_input_out
      && serial_select_input_out) else $error("serial active in pin mode");
   a_range_from_pin: assert property (
      ##1 !$past(code[0][1]) |-> range_870_out == $past(code[0][0])) else $error("range wrong");
   a_swing_from_pin: assert property (
      ##1 !$past(code[0][1]) |-> swing_high_out == $past(code[1] == 2'h1)) else $error("swing wrong");
   a_edge_from_pin: assert property (
      ##1 !$past(code[0][1]) |-> data_edge_pos_out == $past(code[2] == 2'h1)) else $error("edge wrong");
   a_ddr_on_float: assert property (
      ##1 !$past(code[0][1]) |-> ddr_out == $past(code[2][1])) else $error("ddr wrong");
   a_cal_from_pin: assert property (
      ##1 !$past(code[0][1]) |-> cal_delay_long_out == $past(code[3] == 2'h1)) else $error("cal delay wrong");
   a_des_on_float: assert property (
      ##1 !$past(code[0][1]) && $past(code[3][1]) |-> dual_edge_out && !cal_delay_long_out)
      else $error("dual edge wrong");
   a_serial_routed: assert property (
      ##1 $past(code[0][1]) |-> serial_enable_out && serial_clock_out == $past(code[1][0])
      && serial_data_input_out == $past(code[2][0]) && serial_select_input_out == $past(code[3][0]))
      else $error("serial pins not routed");
   // The edge that releases reset still loads the reset value, so start only where reset was high
   a_sync_latency: assert property (
      arst_n_in |-> ##2 code[2] == $past({output_edge_select_float_in, output_edge_select_level_in}, 2))
      else $error("synchroniser latency wrong");

   c_enter_ext: cover property ($rose(ext_mode_out));
   c_ddr_mode: cover property (!ext_mode_out && ddr_out);
   c_dual_edge: cover property (!ext_mode_out && dual_edge_out);
   c_apb_write: cover property (apb_access && pwrite_in);

endmodule : cpmd_decoder

// [core/cpmd_pkg.sv]
/*
 * Shared constants for the control pin mode decoder: pin codes, pin indices,
 * mode encodings, register offsets, field positions and reset values.
 * Assumes nothing of its surroundings; used by every design file of the block.
 */

// ***********************************************
// Control pin mode decoder package
// ***********************************************
package cpmd_pkg;

   // Three-level pin code as {float, level}; a floating pin ignores level
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_HIGH = 2'h1;
   localparam logic [1:0] PIN_FLOAT = 2'h2;
   localparam int PIN_FLOAT_BIT = 1;
   localparam int PIN_LEVEL_BIT = 0;

   // Index of each control pin inside the pin vectors
   localparam int PIN_MODE = 0;
   localparam int PIN_SWING = 1;
   localparam int PIN_EDGE = 2;
   localparam int PIN_CAL = 3;
   localparam int NUM_PINS = 4;

   // Operating mode, one-hot
   typedef enum logic [1:0] {
      CPMD_MODE_PIN = 2'h1,
      CPMD_MODE_EXT = 2'h2
   } cpmd_mode_t;

   // APB register byte offsets
   localparam int ADDR_WIDTH = 8;
   localparam logic [7:0] ADDR_EXT_CFG = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   // Extended configuration register fields
   localparam int CFG_WIDTH = 6;
   localparam int CFG_RANGE_BIT = 0;
   localparam int CFG_SWING_BIT = 1;
   localparam int CFG_EDGE_BIT = 2;
   localparam int CFG_DDR_BIT = 3;
   localparam int CFG_CAL_BIT = 4;
   localparam int CFG_DES_BIT = 5;
   localparam logic [5:0] CFG_RESET = 6'h00;

   // Status register fields: four pin codes, then mode and swing fault
   localparam int STAT_CODES_LSB = 0;
   localparam int STAT_EXT_BIT = 8;
   localparam int STAT_SWING_FAULT_BIT = 9;

   // Synchroniser stage reset value
   localparam logic [1:0] SYNC_RESET = 2'h0;

endpackage : cpmd_pkg

// [core/cpmd_pin_sync.sv]
/*
 * Two-stage synchroniser for one three-level control pin.
 * Assumes the pad sensor gives a level bit and a float bit for the pin.
 */
`timescale 1ns/1ps

// ***********************************************
// Three-level pin synchroniser
// ***********************************************
module cpmd_pin_sync (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   // Pad sensor
   input wire logic level_in,
   input wire logic float_in,
   // Synchronised code {float, level}
   output logic [1:0] code_out
);

   // All synchroniser state
   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } cpmd_sync_t;

   cpmd_sync_t st;
   cpmd_sync_t next_st;

   // First stage is read only by the second, never decoded
   always_comb begin
      next_st = st;
      next_st.stage1 = {float_in, level_in};
      next_st.stage2 = st.stage1;
   end

   // State register
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= {cpmd_pkg::SYNC_RESET, cpmd_pkg::SYNC_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign code_out = st.stage2;

endmodule : cpmd_pin_sync

// [testbench/cpmd_pin_model.sv]
/*
 * Board-side model of the four three-level control pins: straps or serial host.
 * Assumes the bench gives one {float, level} code per pin in step with the core clock.
 */
`timescale 1ns/1ps

// ***********************************************
// Control pin partner model
// ***********************************************
module cpmd_pin_model (
   // Clock
   input wire logic core_clk_in,
   // Requested code per pin, two bits each, mode pin lowest
   input wire logic [7:0] code_in,
   // Pad sensor view
   output logic [3:0] level_out,
   output logic [3:0] float_out
);
   // Flips every cycle so a released pad never shows a stable level
   logic wobble = 1'b0;

   // Free-running pattern for floating pads
   always @(posedge core_clk_in) begin
      wobble <= ~wobble;
   end

   // Driven pins show their level, floating ones only the wobble
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         float_out[i] = code_in[2*i+1];
         level_out[i] = code_in[2*i+1] ? wobble : code_in[2*i];
      end
   end
endmodule : cpmd_pin_model

// [testbench/cpmd_decoder_test.sv]
/*
 * Self-checking bench for the control pin mode decoder: strap table, latency,
 * status and serial routing, APB register access and resets.
 * Assumes the pin model on the pads and a single 250 MHz core clock.
 */
`timescale 1ns/1ps

// ***********************************************
// Decoder testbench
// ***********************************************
module cpmd_decoder_test;
   // Clock, reset and pin codes {cal, edge, swing, mode}
   logic clk, arst_n;
   logic [7:0] codes;
   logic [3:0] lvl, flt;
   // APB master side
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   // Decoded outputs, gathered in register field order
   logic ext_mode, rng, swing, edge_pos, ddr, cal_long, des;
   logic ser_en, ser_clk, ser_data, ser_sel;
   logic [5:0] cfg_seen;
   logic [3:0] ser_seen;
   int fails = 0;
   int n_tests = 0;
   // Strap table rows: {pin codes, expected settings}
   logic [13:0] rows [5] = '{{8'h00, 6'h00}, {8'h55, 6'h17}, {8'hA4, 6'h2A}, {8'h21, 6'h09}, {8'h10, 6'h04}};

   assign cfg_seen = {des, cal_long, ddr, edge_pos, swing, rng};
   assign ser_seen = {ser_en, ser_clk, ser_data, ser_sel};

   // Clock generator, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   cpmd_pin_model u_pins (.core_clk_in(clk), .code_in(codes), .level_out(lvl), .float_out(flt));

   cpmd_decoder u_dut (
      .core_clk_in(clk), .arst_n_in(arst_n),
      .mode_range_level_in(lvl[0]), .mode_range_float_in(flt[0]),
      .output_swing_level_in(lvl[1]), .output_swing_float_in(flt[1]),
      .output_edge_select_level_in(lvl[2]), .output_edge_select_float_in(flt[2]),
      .calibration_delay_select_level_in(lvl[3]), .calibration_delay_select_float_in(flt[3]),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
      .ext_mode_out(ext_mode), .range_870_out(rng), .swing_high_out(swing), .data_edge_pos_out(edge_pos),
      .ddr_out(ddr), .cal_delay_long_out(cal_long), .dual_edge_out(des),
      .serial_enable_out(ser_en), .serial_clock_out(ser_clk),
      .serial_data_input_out(ser_data), .serial_select_input_out(ser_sel));

   // Verdict and end of run, the one place that stops the simulation
   task automatic wrap_up;
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // Compare with case equality so an unknown never matches
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Wait a number of rising edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One APB transfer; waits for pready under a bound, hung slave ends the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         fails++;
         wrap_up();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // Main sequence
   initial begin
      arst_n = 1'b0;
      codes = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      tick(4);
      check("serial_in_reset", 32'h1, 32'(ser_seen));
      arst_n <= 1'b1;
      // Strap table: three pin latency lets four edges settle each row
      foreach (rows[i]) begin
         codes <= rows[i][13:6];
         tick(4);
         check("config", 32'(rows[i][5:0]), 32'(cfg_seen));
         check("ext_mode", 32'h0, 32'(ext_mode));
         check("serial_off", 32'h1, 32'(ser_seen));
      end
      // Pin change must pass two sync stages before the output moves
      codes <= 8'h00;
      tick(2);
      #1;
      check("edge_early", 32'h1, 32'(edge_pos));
      tick(1);
      #1;
      check("edge_late", 32'h0, 32'(edge_pos));
      // Floating swing pin in strap mode reads low and flags status
      @(posedge clk);
      codes <= 8'h08;
      tick(4);
      check("swing_float", 32'h0, 32'(swing));
      apb(1'b0, cpmd_pkg::ADDR_STATUS, 32'h0000_0000);
      check("status_fault", 32'h2, 32'(rd[9:8]));
      apb(1'b0, 8'h08, 32'h0000_0000);
      check("unmapped", 32'h1, {rd[30:0], err});
      // Extended mode: settings from the register, pins carry the serial bus
      codes <= 8'h46;
      tick(4);
      check("ext_on", 32'h1, 32'(ext_mode));
      check("serial_a", 32'hD, 32'(ser_seen));
      apb(1'b1, cpmd_pkg::ADDR_EXT_CFG, 32'hFFFF_FFFF);
      apb(1'b0, cpmd_pkg::ADDR_EXT_CFG, 32'h0000_0000);
      check("cfg_read", 32'h3F, rd);
      apb(1'b1, cpmd_pkg::ADDR_EXT_CFG, 32'h0000_002D);
      tick(2);
      check("cfg_out", 32'h2D, 32'(cfg_seen));
      codes <= 8'h12;
      tick(4);
      check("serial_b", 32'hA, 32'(ser_seen));
      check("cfg_hold", 32'h2D, 32'(cfg_seen));
      // Reset in mid-run clears at once, then the mode pin decides again
      arst_n <= 1'b0;
      #1;
      check("mid_reset", 32'h1, 32'({ext_mode, ser_seen}));
      tick(1);
      arst_n <= 1'b1;
      tick(4);
      check("after_reset", 32'h40, 32'({ext_mode, cfg_seen}));
      wrap_up();
   end
endmodule : cpmd_decoder_test
